// ===== core/tsense_pkg.sv
package tsense_pkg;
  // register indices (6-bit internal address)
  localparam logic [5:0] ADDR_SLAVE_ID = 6'h00;
  localparam logic [5:0] ADDR_MAKER = 6'h01;
  localparam logic [5:0] ADDR_PART = 6'h02;
  localparam logic [5:0] ADDR_FIXCAP = 6'h03;
  localparam logic [5:0] ADDR_STATUS = 6'h04;
  localparam logic [5:0] ADDR_GCTRL = 6'h05;
  localparam logic [5:0] ADDR_TCAP = 6'h08;
  localparam logic [5:0] ADDR_TREAD = 6'h09;
  localparam logic [5:0] ADDR_TCTRL = 6'h0a;
  localparam logic [5:0] ADDR_RATE = 6'h20;

  // constant register values; identity codes are arbitrary
  localparam logic [15:0] MAKER_VAL = 16'h5aa5;
  localparam logic [15:0] PART_VAL = 16'h00c3;
  localparam logic [15:0] FIXCAP_VAL = 16'h0001;
  localparam logic [15:0] TCAP_VAL = 16'h014a;

  // reset values
  localparam logic [15:0] GCTRL_RST = 16'h0000;
  localparam logic [15:0] TCTRL_RST = 16'h0000;
  localparam logic [1:0] RATE_RST = 2'h2;

  // field positions
  localparam int STAT_BUS_ERR_BIT = 7;
  localparam int STAT_FUNC_ERR_BIT = 4;
  localparam int STAT_FUNC_STAT_BIT = 0;
  localparam int GCTRL_RESET_BIT = 0;
  localparam int GCTRL_EN_BIT = 4;
  localparam int TCTRL_OUT_BIT = 1;
  localparam int TCTRL_MODE_BIT = 0;
  localparam int TREAD_LSB = 6;

  // one register access from the link framer
  typedef struct packed {
    logic rd;
    logic wr;
    logic [5:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  // function-side event inputs
  typedef struct packed {
    logic func_event;
    logic func_error;
    logic func_handled;
    logic bus_error;
  } evt_in_t;

  // whole block state
  typedef struct packed {
    logic bus_error_flag;
    logic function_error_flag;
    logic function_status_flag;
    logic attn_armed;
    logic func_pending;
    logic [15:0] gctrl;
    logic [15:0] tctrl;
    logic [1:0] rate;
    logic [15:0] temp;
    logic [15:0] rdata;
    logic attn_req;
  } state_t;
endpackage

// ===== core/tsense_regbank.sv
// Function
// - no repeated function attention until status register is read or a bus reset arrives.
// - device number comes only from two straps; writes cannot change it.
// - after device reset, device number field shows strap address.
// - status read-only, reset zero: bus error b7, func error b4, status b0.
// - rate register at 0x20 reads/writes, resets to 2, two-bit field.
// - straps 00..11 map continuously to numbers 001..100.
// - writing reset bit of control returns every register to default.
module tsense_regbank (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // straps
  input wire logic addr_strap_low,
  input wire logic addr_strap_high,
  // register access from the link framer
  input wire tsense_pkg::reg_req_t req,
  output logic [15:0] rdata,
  // bus idle, attention request out
  input wire logic bus_idle,
  input wire logic bus_reset,
  output logic attn_req,
  // function side
  input wire tsense_pkg::evt_in_t evt,
  input wire logic temp_valid,
  input wire logic [9:0] temp_code,
  output logic [1:0] rate_sel,
  output logic [15:0] thermal_ctrl,
  output logic function_event_enable,
  output logic dev_reset
);
  tsense_pkg::state_t s_reg, s_next;
  logic [2:0] assigned_address_field;
  logic soft_rst;
  logic [7:0] status_byte;

  // strap decode, follows pins continuously
  // strap mapping
  assign assigned_address_field =
    3'({addr_strap_high, addr_strap_low}) + 3'h1;

  assign status_byte = {s_reg.bus_error_flag, 2'h0,
    s_reg.function_error_flag, 3'h0, s_reg.function_status_flag};

  assign soft_rst = req.wr && (req.addr == tsense_pkg::ADDR_GCTRL) &&
    req.wdata[tsense_pkg::GCTRL_RESET_BIT];

  // next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.attn_req = 1'b0;
    // function flags: set wins over handling clear
    if (evt.func_handled) begin
      s_next.function_status_flag = 1'b0;
      s_next.function_error_flag = 1'b0;
    end
    if (evt.func_event) begin
      s_next.function_status_flag = 1'b1;
      s_next.func_pending = 1'b1;
    end
    if (evt.func_error) begin
      s_next.function_error_flag = 1'b1;
    end
    if (evt.bus_error) begin
      s_next.bus_error_flag = 1'b1;
    end
    if (temp_valid) begin
      s_next.temp = {temp_code, 6'h00};
    end
    // register reads and writes
    if (req.rd) begin
      unique case (req.addr)
        tsense_pkg::ADDR_SLAVE_ID: s_next.rdata = {13'h0,
          assigned_address_field};
        tsense_pkg::ADDR_MAKER: s_next.rdata = tsense_pkg::MAKER_VAL;
        tsense_pkg::ADDR_PART: s_next.rdata = tsense_pkg::PART_VAL;
        tsense_pkg::ADDR_FIXCAP: s_next.rdata = tsense_pkg::FIXCAP_VAL;
        tsense_pkg::ADDR_STATUS: s_next.rdata = {8'h00, status_byte};
        tsense_pkg::ADDR_GCTRL: s_next.rdata = s_reg.gctrl;
        tsense_pkg::ADDR_TCAP: s_next.rdata = tsense_pkg::TCAP_VAL;
        tsense_pkg::ADDR_TREAD: s_next.rdata = s_reg.temp;
        tsense_pkg::ADDR_TCTRL: s_next.rdata = s_reg.tctrl;
        tsense_pkg::ADDR_RATE: s_next.rdata = {14'h0, s_reg.rate};
        default: s_next.rdata = 16'h0000;
      endcase
      if (req.addr == tsense_pkg::ADDR_STATUS) begin
        s_next.attn_armed = 1'b1;
      end
    end
    if (req.wr) begin
      unique case (req.addr)
        tsense_pkg::ADDR_GCTRL: s_next.gctrl = req.wdata;
        tsense_pkg::ADDR_TCTRL: s_next.tctrl = req.wdata;
        tsense_pkg::ADDR_RATE: s_next.rate = req.wdata[1:0];
        default: s_next.rate = s_next.rate;
      endcase
    end
    if (bus_reset) begin
      s_next.attn_armed = 1'b1;
    end
    // attention: bus error always, function event once per status read or bus reset
    if (bus_idle && s_reg.bus_error_flag) begin
      s_next.attn_req = 1'b1;
      s_next.bus_error_flag = evt.bus_error;
    end else if (bus_idle && s_reg.func_pending) begin
      // first idle after the event decides; an event now still wins
      s_next.func_pending = evt.func_event;
      if (s_reg.gctrl[tsense_pkg::GCTRL_EN_BIT] && s_reg.attn_armed) begin
        s_next.attn_req = 1'b1;
        s_next.attn_armed = 1'b0;
      end
    end
  end

  // state register with reset defaults
  always_ff @(posedge clk_sys) begin
    if (srst || (ce && soft_rst)) begin
      s_reg <= '0;
      s_reg.attn_armed <= 1'b1;
      s_reg.gctrl <= tsense_pkg::GCTRL_RST;
      s_reg.tctrl <= tsense_pkg::TCTRL_RST;
      s_reg.rate <= tsense_pkg::RATE_RST;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // outputs
  assign rdata = s_reg.rdata;
  assign attn_req = s_reg.attn_req;
  assign rate_sel = s_reg.rate;
  assign thermal_ctrl = s_reg.tctrl;
  assign function_event_enable = s_reg.gctrl[tsense_pkg::GCTRL_EN_BIT];
  assign dev_reset = srst || (ce && soft_rst);

  // assertions
  // rate default after reset
  property p_rate_rst;
    @(posedge clk_sys) srst |=>
      rate_sel == tsense_pkg::RATE_RST && !attn_req;
  endproperty
  a_rate_rst: assert property (p_rate_rst)
    else $error("rate reset bad");
  // no function request right after another
  property p_single_attn;
    @(posedge clk_sys) disable iff (srst)
    (ce && attn_req && $past(ce) && !s_reg.bus_error_flag &&
      !$past(s_reg.bus_error_flag)) |=> !attn_req;
  endproperty
  a_single_attn: assert property (p_single_attn)
    else $error("attn repeat");
  // function request leaves the block disarmed
  property p_attn_disarm;
    @(posedge clk_sys) disable iff (srst)
    attn_req && $past(ce) && !$past(s_reg.bus_error_flag) |->
      !s_reg.attn_armed;
  endproperty
  a_attn_disarm: assert property (p_attn_disarm)
    else $error("still armed after request");
  property p_id;
    @(posedge clk_sys) disable iff (srst)
    ce && req.rd && req.addr == tsense_pkg::ADDR_SLAVE_ID && !soft_rst |=>
      rdata == {13'h0, 3'($past(assigned_address_field))};
  endproperty
  a_id: assert property (p_id)
    else $error("device number bad");
  property p_soft;
    @(posedge clk_sys) disable iff (srst) ce && soft_rst |=>
      thermal_ctrl == tsense_pkg::TCTRL_RST &&
      rate_sel == tsense_pkg::RATE_RST && !attn_req;
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset bad");
  // bus error flag set, set wins
  property p_bus_err_set;
    @(posedge clk_sys) disable iff (srst) ce && evt.bus_error && !soft_rst
      |=> s_reg.bus_error_flag;
  endproperty
  a_bus_err_set: assert property (p_bus_err_set)
    else $error("bus error lost");
  // function status flag set, set wins
  property p_func_set;
    @(posedge clk_sys) disable iff (srst)
    ce && evt.func_event && !soft_rst |=> s_reg.function_status_flag;
  endproperty
  a_func_set: assert property (p_func_set)
    else $error("function status lost");
  // function error flag set, set wins
  property p_err_set;
    @(posedge clk_sys) disable iff (srst)
    ce && evt.func_error && !soft_rst |=> s_reg.function_error_flag;
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("function error lost");
  property p_temp;
    @(posedge clk_sys) disable iff (srst) s_reg.temp[5:0] == 6'h00;
  endproperty
  a_temp: assert property (p_temp)
    else $error("temp low bits");
  // clock enable low holds every state bit
  property p_freeze;
    @(posedge clk_sys) !ce && !srst |=> $stable(s_reg);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while frozen");
  // main scenarios reached
  c_attn: cover property (@(posedge clk_sys) attn_req);
  c_soft: cover property (@(posedge clk_sys) ce && soft_rst);
  c_stat: cover property (@(posedge clk_sys)
    req.rd && req.addr == tsense_pkg::ADDR_STATUS);
  c_bus_err_attn: cover property (@(posedge clk_sys)
    ce && bus_idle && s_reg.bus_error_flag);
  c_held: cover property (@(posedge clk_sys)
    ce && bus_idle && s_reg.func_pending && !s_reg.attn_armed);
endmodule

// ===== testbench/tsense_master.sv
module tsense_master (
  // clock
  input wire logic clk_sys,
  // register access toward the slave
  output tsense_pkg::reg_req_t req,
  input wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // one access: pulse for one edge, read data a cycle later
  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(negedge clk_sys);
    req = '{rd: !w, wr: w, addr: a, wdata: d};
    @(negedge clk_sys);
    req = '0;
    q = rdata;
  endtask
  // probe by device number, zero means empty, parity unused
  task automatic probe(input logic [5:0] a, output logic here);
    logic [15:0] q;
    acc(1'b0, a, 16'h0000, q);
    here = (q[2:0] != 3'h0);
  endtask
  // scan step reads the event status of one slave
  task automatic scan(output logic [15:0] q);
    acc(1'b0, tsense_pkg::ADDR_STATUS, 16'h0000, q);
  endtask
endmodule

// ===== testbench/tsense_regbank_tb_top.sv
module tsense_regbank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, srst = 1, ce = 1, s_lo = 0, s_hi = 0, here;
  logic bus_idle = 0, bus_reset = 0, temp_valid = 0, attn_req;
  logic [9:0] temp_code = 10'h000;
  logic [15:0] rdata, q;
  tsense_pkg::reg_req_t req;
  tsense_pkg::evt_in_t evt = '0;
  logic [1:0] rate_sel;
  logic [15:0] thermal_ctrl;
  logic func_en, dev_reset;
  int fails = 0, tests_run = 0, attn_cnt = 0;
  int rst_cnt = 0, base = 0;
  // event pulse patterns: event, error, handled, bus error
  localparam tsense_pkg::evt_in_t EV_FUNC = 4'h8;
  localparam tsense_pkg::evt_in_t EV_ERR = 4'h4;
  localparam tsense_pkg::evt_in_t EV_DONE = 4'h2;
  localparam tsense_pkg::evt_in_t EV_BUS = 4'h1;
  localparam tsense_pkg::evt_in_t EV_BOTH = 4'ha;
  logic [5:0] ra [10] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04,
    6'h05, 6'h08, 6'h0a, 6'h20, 6'h3f};
  logic [15:0] rv [10] = '{16'h0001, tsense_pkg::MAKER_VAL,
    tsense_pkg::PART_VAL, 16'h0001, 16'h0000, 16'h0000, 16'h014a,
    16'h0000, 16'h0002, 16'h0000};
  // clock, attention and reset pulse counters
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (attn_req === 1'b1) attn_cnt <= attn_cnt + 1;
  always @(posedge clk_sys) if (dev_reset === 1'b1) rst_cnt <= rst_cnt + 1;
  tsense_master tsense_master_inst (.clk_sys(clk_sys), .req(req),
    .rdata(rdata));
  tsense_regbank tsense_regbank_inst (.clk_sys(clk_sys), .srst(srst),
    .ce(ce), .addr_strap_low(s_lo), .addr_strap_high(s_hi), .req(req),
    .rdata(rdata), .bus_idle(bus_idle), .bus_reset(bus_reset),
    .attn_req(attn_req), .evt(evt), .temp_valid(temp_valid),
    .temp_code(temp_code), .rate_sel(rate_sel),
    .thermal_ctrl(thermal_ctrl), .function_event_enable(func_en),
    .dev_reset(dev_reset));
  task automatic chk(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [15:0] d);
    tsense_master_inst.acc(w, a, d, q);
  endtask
  // one-cycle event pulse, then settle time
  task automatic evt_pulse(input tsense_pkg::evt_in_t e);
    @(negedge clk_sys);
    evt = e;
    @(negedge clk_sys);
    evt = '0;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic test_reset_map();
    for (int i = 0; i < 10; i++) begin
      acc(1'b0, ra[i], 16'h0000);
      chk("reset value", rv[i], q);
    end
    tsense_master_inst.probe(6'h00, here);
    chk("present", 16'h0001, {15'h0, here});
    $display("test reset_map done");
  endtask
  task automatic test_straps();
    for (int i = 0; i < 4; i++) begin
      {s_hi, s_lo} = i[1:0];
      acc(1'b1, 6'h00, 16'hffff);
      acc(1'b0, 6'h00, 16'h0000);
      chk("device number", 16'(i + 1), q);
    end
    $display("test straps done");
  endtask
  task automatic test_rate_reset();
    acc(1'b1, 6'h20, 16'h00ff);
    acc(1'b0, 6'h20, 16'h0000);
    chk("rate field", 16'h0003, q);
    chk("rate_sel", 16'h0003, {14'h0, rate_sel});
    acc(1'b1, 6'h0a, 16'h0003);
    chk("thermal_ctrl", 16'h0003, thermal_ctrl);
    base = rst_cnt;
    acc(1'b1, 6'h05, 16'h0001);
    chk("dev_reset pulses", 16'h0001, 16'(rst_cnt - base));
    acc(1'b0, 6'h20, 16'h0000);
    chk("rate after reset", 16'h0002, q);
    chk("thermal_ctrl reset", 16'h0000, thermal_ctrl);
    $display("test rate_reset done");
  endtask
  task automatic test_attention();
    acc(1'b1, 6'h05, 16'h0010);
    chk("event enable", 16'h0001, {15'h0, func_en});
    bus_idle = 1'b1;
    base = attn_cnt;
    evt_pulse(EV_FUNC);
    evt_pulse(EV_FUNC);
    chk("one request", 16'h0001, 16'(attn_cnt - base));
    tsense_master_inst.scan(q);
    chk("status", 16'h0001, q);
    repeat (4) @(negedge clk_sys);
    chk("no resend", 16'h0001, 16'(attn_cnt - base));
    evt_pulse(EV_FUNC);
    chk("rearmed by read", 16'h0002, 16'(attn_cnt - base));
    @(negedge clk_sys);
    bus_reset = 1'b1;
    @(negedge clk_sys);
    bus_reset = 1'b0;
    evt_pulse(EV_FUNC);
    chk("rearmed by bus reset", 16'h0003, 16'(attn_cnt - base));
    evt_pulse(EV_ERR);
    tsense_master_inst.scan(q);
    chk("status error", 16'h0011, q);
    evt_pulse(EV_BOTH);
    tsense_master_inst.scan(q);
    chk("status set wins", 16'h0001, q);
    chk("new event request", 16'h0004, 16'(attn_cnt - base));
    evt_pulse(EV_DONE);
    tsense_master_inst.scan(q);
    chk("status handled", 16'h0000, q);
    bus_idle = 1'b0;
    evt_pulse(EV_BUS);
    tsense_master_inst.scan(q);
    chk("status bus error", 16'h0080, q);
    chk("held while busy", 16'h0004, 16'(attn_cnt - base));
    bus_idle = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("bus error request", 16'h0005, 16'(attn_cnt - base));
    $display("test attention done");
  endtask
  // enable low ignores a write; a mid-run reset restores defaults
  task automatic test_freeze_reset();
    acc(1'b1, 6'h20, 16'h0001);
    ce = 1'b0;
    acc(1'b1, 6'h20, 16'h0003);
    ce = 1'b1;
    acc(1'b0, 6'h20, 16'h0000);
    chk("rate frozen", 16'h0001, q);
    evt_pulse(EV_FUNC);
    @(negedge clk_sys);
    srst = 1'b1;
    @(negedge clk_sys);
    srst = 1'b0;
    acc(1'b0, 6'h20, 16'h0000);
    chk("rate after srst", 16'h0002, q);
    acc(1'b0, 6'h04, 16'h0000);
    chk("status after srst", 16'h0000, q);
    $display("test freeze_reset done");
  endtask
  task automatic test_temp();
    temp_code = 10'h2c5;
    temp_valid = 1'b1;
    @(negedge clk_sys);
    temp_valid = 1'b0;
    acc(1'b0, 6'h09, 16'h0000);
    chk("readout", 16'hb140, q);
    $display("test temp done");
  endtask
  task automatic complete_run();
    $display("tests_run %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog against a hung run
  initial begin
    #200us;
    fails++;
    complete_run();
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    chk("reset pulses", 16'h0008, 16'(rst_cnt));
    srst = 1'b0;
    test_reset_map();
    test_straps();
    test_rate_reset();
    test_attention();
    test_freeze_reset();
    test_temp();
    complete_run();
  end
endmodule
